// file: core/vic_edge_detect.sv
// Purpose : Edge detector for the external interrupt pin.
// Assumes : Pin level is synchronous to pclk.
// Notes   : The hit is registered, one cycle after the edge.
`timescale 1ns/1ns
module vic_edge_detect
  import vic_pkg::*;
(
  input  wire logic pclk,     // System clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  vic_edge_if.det   eif       // Edge select, pin level, hit.
);

  logic pin_q;
  logic hit_q;
  logic seen_q;
  wire  rise = eif.pin_level & ~pin_q;
  wire  fall = ~eif.pin_level & pin_q;
  wire  hit_d = ((eif.edge_sel == VIC_EDGE_RISE) & rise) |
                ((eif.edge_sel == VIC_EDGE_FALL) & fall) |
                ((eif.edge_sel == VIC_EDGE_BOTH) & (rise | fall));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_q  <= 1'b0;
      hit_q  <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      // The first sample after reset only primes pin_q, so an idle pin gives no false edge.
      pin_q  <= eif.pin_level;
      hit_q  <= hit_d & seen_q;
      seen_q <= 1'b1;
    end
  end

  assign eif.edge_hit = hit_q;

endmodule : vic_edge_detect

// file: core/vic_edge_if.sv
// Purpose : Carries edge selection, pin level and detected edge.
// Assumes : Single clock domain.
// Notes   : None.
`timescale 1ns/1ns
interface vic_edge_if;
  logic [1:0] edge_sel;
  logic       pin_level;
  logic       edge_hit;
  modport det (input edge_sel, input pin_level, output edge_hit);
  modport ctl (output edge_sel, output pin_level, input edge_hit);
endinterface : vic_edge_if

// file: core/vic_pkg.sv
// Purpose : Shared constants for the vectored interrupt controller.
// Assumes : APB with 32-bit data, one aligned word per register.
// Notes   : Source index order is also the fixed service priority.
package vic_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] VIC_OFS_PRIMARY   = 8'h00;
  localparam logic [7:0] VIC_OFS_SECONDARY = 8'h04;
  localparam logic [7:0] VIC_OFS_EDGE      = 8'h08;
  localparam logic [7:0] VIC_OFS_STATUS    = 8'h0c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int VIC_P_MASTER_EN = 0;
  localparam int VIC_P_EXT_EN    = 1;
  localparam int VIC_P_T0_EN     = 2;
  localparam int VIC_P_T1_EN     = 3;
  localparam int VIC_P_EXT_F     = 4;
  localparam int VIC_P_T0_F      = 5;
  localparam int VIC_P_T1_F      = 6;
  localparam int VIC_S_ADC_EN    = 0;
  localparam int VIC_S_TB_EN     = 1;
  localparam int VIC_S_ADC_F     = 4;
  localparam int VIC_S_TB_F      = 5;
  localparam int VIC_E_SEL_LO    = 6;
  localparam int VIC_E_SEL_HI    = 7;

  // ----------------------------------------------------------------
  // Sources, vectors, reset values and timing
  // ----------------------------------------------------------------
  localparam int          VIC_NSRC     = 5;
  localparam logic [2:0]  VIC_SRC_EXT  = 3'h0;
  localparam logic [2:0]  VIC_SRC_T0   = 3'h1;
  localparam logic [2:0]  VIC_SRC_T1   = 3'h2;
  localparam logic [2:0]  VIC_SRC_ADC  = 3'h3;
  localparam logic [2:0]  VIC_SRC_TB   = 3'h4;
  localparam logic [7:0]  VIC_VEC_BASE = 8'h04;
  localparam logic [7:0]  VIC_REG_RST  = 8'h00;
  localparam logic [1:0]  VIC_EDGE_OFF = 2'h0;
  localparam logic [1:0]  VIC_EDGE_RISE = 2'h1;
  localparam logic [1:0]  VIC_EDGE_FALL = 2'h2;
  localparam logic [1:0]  VIC_EDGE_BOTH = 2'h3;
  localparam int          VIC_LAT_NORMAL = 2;
  localparam int          VIC_LAT_LONG   = 3;

  typedef enum logic [2:0] {
    VIC_ST_IDLE  = 3'b001,
    VIC_ST_WAIT  = 3'b010,
    VIC_ST_ENTER = 3'b100
  } vic_state_e;

endpackage : vic_pkg

// file: core/vic_top.sv
// Purpose : Prioritised vectored interrupt controller with APB registers.
// Assumes : instr_tick pulses once per instruction cycle (phase-two edge).
// Notes   : Zero-wait APB slave; unmapped addresses answer pslverr.
//
// Notes on behaviour
// - Source event sets its request flag when its own enable is set.
// - Accepted request pushes next address and loads the source vector.
// - Return-from-interrupt pops the saved address, resuming the program.
// - Entering service clears master enable, blocking nesting.
// - Flags keep latching while master enable is clear.
// - No acknowledge while the stack is full; wait for a pop.
// - Vector reached two or three instruction cycles after request.
// - Waking from sleep takes three instruction cycles to the vector.
// - Requests are sampled once per instruction cycle, at phase-two edge.
// - Fixed priority: external, timer 0, timer 1, conversion, time base.
// - Master enable at primary bit 0 gates all servicing.
// - Two-bit edge select: off, rising, falling, both.
// - External interrupt needs master and external enable plus edge flag.
// - Servicing clears the serviced source's request flag.
// - Pull-high on the shared pin stays active in interrupt use.
// - Primary bits 6..4 hold timer 1, timer 0, external flags.
// - Primary bits 3..1 hold enables; all bits reset to zero.
// - Secondary holds conversion, time base flags 4,5 and enables 0,1.
// - A set flag stays set until serviced or cleared by software.
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module vic_top
  import vic_pkg::*;
#(
  parameter int LAT_NORMAL = VIC_LAT_NORMAL,  // Instruction cycles to vector.
  parameter int LAT_LONG   = VIC_LAT_LONG     // Cycles when stretched or waking.
)
(
  input  wire logic        pclk,            // System clock, 25 MHz.
  input  wire logic        presetn,         // Asynchronous reset, active low.
  input  wire logic        psel,            // APB select.
  input  wire logic        penable,         // APB enable.
  input  wire logic        pwrite,          // APB write direction.
  input  wire logic [7:0]  paddr,           // APB byte address.
  input  wire logic [31:0] pwdata,          // APB write data.
  output logic      [31:0] prdata,          // APB read data.
  output logic             pready,          // APB ready.
  output logic             pslverr,         // APB error on unmapped address.
  input  wire logic        instr_tick,      // Phase-two edge, once per cycle.
  input  wire logic        instr_long,      // Core needs an extra cycle.
  input  wire logic        sleep_mode,      // Core is in sleep.
  input  wire logic        stack_full,      // Return stack has no room.
  input  wire logic        return_from_irq_instr_exec,       // Return-from-irq executed.
  input  wire logic        ext_pin,         // Shared port line 3 level.
  input  wire logic        port_a_dir_bit3, // Port line 3 is an input.
  input  wire logic        pull_high_en,    // Pull-high requested for line 3.
  input  wire logic        timer0_ovf,      // Timer 0 overflow pulse.
  input  wire logic        timer1_ovf,      // Timer 1 overflow pulse.
  input  wire logic        conv_done,       // Conversion complete pulse.
  input  wire logic        timebase_ovf,    // Time base overflow pulse.
  output logic             irq_enter,       // Push next PC, load vector.
  output logic      [7:0]  irq_vector,      // Vector to load.
  output logic             pc_pop,          // Pop saved PC to resume.
  output logic             wake_req,        // Pending request while asleep.
  output logic             pull_high_out    // Pull-high drive for line 3.
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The wait counter is three bits wide, which bounds the longer latency.
  if (LAT_NORMAL < 1 || LAT_LONG < LAT_NORMAL || LAT_LONG > 7)
  begin : g_bad_lat
    $error("vic_top: latency parameters out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [VIC_NSRC-1:0] flag_q;
  logic [VIC_NSRC-1:0] flag_d;
  logic [VIC_NSRC-1:0] en_q;
  logic                master_q;
  logic                master_d;
  logic [1:0]          edge_sel_q;
  vic_state_e          state_q;
  vic_state_e          state_d;
  logic [2:0]          cnt_q;
  logic [2:0]          cnt_d;
  logic [2:0]          win_q;
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;
  logic                enter_q;
  logic [7:0]          vector_q;
  logic                pop_q;
  logic                wake_q;
  logic                pull_q;

  // The pin detector hands over one registered pulse per qualifying edge,
  // so the flag logic sees each edge exactly once.
  vic_edge_if eif ();

  assign eif.edge_sel  = edge_sel_q;
  assign eif.pin_level = ext_pin;

  vic_edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .eif     (eif)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Writes land at the access edge; the response registers look only at the
  // setup cycle, so the slave never inserts a wait state.
  wire setup_ph  = psel & ~penable;
  wire wr_now    = psel & penable & pready_q & pwrite;
  wire hit_pri   = (paddr == VIC_OFS_PRIMARY);
  wire hit_sec   = (paddr == VIC_OFS_SECONDARY);
  wire hit_edge  = (paddr == VIC_OFS_EDGE);
  wire hit_stat  = (paddr == VIC_OFS_STATUS);
  wire mapped    = hit_pri | hit_sec | hit_edge | hit_stat;
  wire wr_pri    = wr_now & hit_pri;
  wire wr_sec    = wr_now & hit_sec;
  wire wr_edge   = wr_now & hit_edge;

  // ----------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------
  wire [7:0] rd_pri  = {1'b0,
                        flag_q[VIC_SRC_T1], flag_q[VIC_SRC_T0], flag_q[VIC_SRC_EXT],
                        en_q[VIC_SRC_T1], en_q[VIC_SRC_T0], en_q[VIC_SRC_EXT],
                        master_q};
  wire [7:0] rd_sec  = {2'b00, flag_q[VIC_SRC_TB], flag_q[VIC_SRC_ADC],
                        2'b00, en_q[VIC_SRC_TB], en_q[VIC_SRC_ADC]};
  wire [7:0] rd_edge = {edge_sel_q, 6'h00};
  wire [7:0] rd_stat = {2'b00, win_q, state_q};
  wire [7:0] rd_sel  = hit_pri  ? rd_pri  :
                       hit_sec  ? rd_sec  :
                       hit_edge ? rd_edge :
                       hit_stat ? rd_stat : 8'h00;

  // Write values for the flag and enable bits, indexed by source.
  wire [VIC_NSRC-1:0] wr_flag_hit = {wr_sec, wr_sec, wr_pri, wr_pri, wr_pri};
  wire [VIC_NSRC-1:0] wr_flag_val = {pwdata[VIC_S_TB_F], pwdata[VIC_S_ADC_F],
                                     pwdata[VIC_P_T1_F], pwdata[VIC_P_T0_F],
                                     pwdata[VIC_P_EXT_F]};
  wire [VIC_NSRC-1:0] wr_en_val   = {pwdata[VIC_S_TB_EN], pwdata[VIC_S_ADC_EN],
                                     pwdata[VIC_P_T1_EN], pwdata[VIC_P_T0_EN],
                                     pwdata[VIC_P_EXT_EN]};

  // ----------------------------------------------------------------
  // Events and priority
  // ----------------------------------------------------------------
  // The pin only counts while it is configured as an input.
  wire ext_evt = eif.edge_hit & port_a_dir_bit3;
  wire [VIC_NSRC-1:0] evt = {timebase_ovf, conv_done, timer1_ovf, timer0_ovf, ext_evt};
  wire [VIC_NSRC-1:0] set_evt = evt & en_q;
  wire [VIC_NSRC-1:0] pend    = flag_q & en_q;

  wire [2:0] win_idx = pend[VIC_SRC_EXT] ? VIC_SRC_EXT :
                       pend[VIC_SRC_T0]  ? VIC_SRC_T0  :
                       pend[VIC_SRC_T1]  ? VIC_SRC_T1  :
                       pend[VIC_SRC_ADC] ? VIC_SRC_ADC : VIC_SRC_TB;
  wire any_pend = |pend;
  wire accept   = instr_tick & master_q & any_pend & ~stack_full;
  wire [2:0] lat = (sleep_mode | instr_long) ? 3'(LAT_LONG) : 3'(LAT_NORMAL);
  wire enter_now = (state_q == VIC_ST_ENTER) & ~stack_full;
  wire [7:0] vec_calc = 8'(VIC_VEC_BASE + {3'h0, win_q, 2'b00});

  // ----------------------------------------------------------------
  // Service sequence
  // ----------------------------------------------------------------
  // A later, higher-priority arrival waits for the next round. Entry also
  // waits while the stack is full, so a late return only delays the push
  // and never loses the request.
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      VIC_ST_IDLE:
      begin
        if (accept)
        begin
          cnt_d   = 3'(lat - 3'h1);
          state_d = (lat == 3'h1) ? VIC_ST_ENTER : VIC_ST_WAIT;
        end
      end
      VIC_ST_WAIT:
      begin
        if (instr_tick)
        begin
          cnt_d = 3'(cnt_q - 3'h1);
          if (cnt_q == 3'h1)
          begin
            state_d = VIC_ST_ENTER;
          end
        end
      end
      VIC_ST_ENTER:
      begin
        if (enter_now)
        begin
          state_d = VIC_ST_IDLE;
        end
      end
      default:
      begin
        state_d = VIC_ST_IDLE;
        cnt_d   = 3'h0;
      end
    endcase
  end

  // Master enable: cleared on entry, software write otherwise.
  assign master_d = enter_now ? 1'b0 :
                    wr_pri    ? pwdata[VIC_P_MASTER_EN] :
                    master_q;

  // ----------------------------------------------------------------
  // Request flags, one per source
  // ----------------------------------------------------------------
  genvar gi;
  for (gi = 0; gi < VIC_NSRC; gi++)
  begin : g_src
    wire svc_clr = enter_now & (win_q == 3'(gi));
    // A hardware event wins over a software or service clear.
    assign flag_d[gi] = set_evt[gi]     ? 1'b1 :
                        wr_flag_hit[gi] ? wr_flag_val[gi] :
                        svc_clr         ? 1'b0 :
                        flag_q[gi];

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        flag_q[gi] <= 1'b0;
        en_q[gi]   <= 1'b0;
      end
      else
      begin
        flag_q[gi] <= flag_d[gi];
        if (wr_flag_hit[gi])
        begin
          en_q[gi] <= wr_en_val[gi];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // The winner is latched only at accept, so the vector loaded later and
  // the flag cleared at entry always belong to the same source.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      master_q   <= 1'b0;
      edge_sel_q <= VIC_EDGE_OFF;
      state_q    <= VIC_ST_IDLE;
      cnt_q      <= 3'h0;
      win_q      <= 3'h0;
    end
    else
    begin
      master_q <= master_d;
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      if (wr_edge)
      begin
        edge_sel_q <= {pwdata[VIC_E_SEL_HI], pwdata[VIC_E_SEL_LO]};
      end
      if (accept && state_q == VIC_ST_IDLE)
      begin
        win_q <= win_idx;
      end
    end
  end

  // ----------------------------------------------------------------
  // Core-side outputs
  // ----------------------------------------------------------------
  // The pop follows the return by one clock. The wake request is a level
  // that stays up in sleep while any enabled flag is set, whatever the master enable,
  // so a masked source still ends sleep.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enter_q  <= 1'b0;
      vector_q <= 8'h00;
      pop_q    <= 1'b0;
      wake_q   <= 1'b0;
      pull_q   <= 1'b0;
    end
    else
    begin
      enter_q <= enter_now;
      if (enter_now)
      begin
        vector_q <= vec_calc;
      end
      pop_q  <= return_from_irq_instr_exec;
      wake_q <= sleep_mode & any_pend;
      pull_q <= pull_high_en;
    end
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------
  // Every setup cycle is answered in the access cycle that follows.
  // Writes to the status register are ignored and raise no error.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & ~mapped;
      if (setup_ph)
      begin
        prdata_q <= {24'h00_0000, (pwrite ? VIC_REG_RST : rd_sel)};
      end
    end
  end

  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign irq_enter     = enter_q;
  assign irq_vector    = vector_q;
  assign pc_pop        = pop_q;
  assign wake_req      = wake_q;
  assign pull_high_out = pull_q;

endmodule : vic_top

// file: verification/vic_core_model.sv
// Purpose: Core sequencer model: instruction ticks, stack and returns.
// Assumes: Every entry is followed by a routine that ends in a return.
// Notes  : The bench may force the stack full.
`timescale 1ns/1ns
module vic_core_model #(
  parameter int TICK_GAP = 3,  // Clocks per instruction cycle.
  parameter int DEPTH    = 4,  // Stack levels.
  parameter int ISR_LEN  = 5   // Clocks inside a routine.
)
(
  input  wire logic pclk,        // Clock.
  input  wire logic presetn,     // Reset.
  input  wire logic irq_enter,   // Entry pulse.
  input  wire logic hold_full,   // Force stack full.
  output logic      instr_tick,  // Phase-two pulse.
  output logic      return_from_irq_instr_exec,   // Return executed.
  output logic      stack_full   // No stack room.
);
  int gap_q;
  int depth_q;
  int isr_q;
  assign stack_full = hold_full || (depth_q >= DEPTH);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gap_q      <= 0;
      depth_q    <= 0;
      isr_q      <= 0;
      instr_tick <= 1'b0;
      return_from_irq_instr_exec  <= 1'b0;
    end
    else
    begin
      gap_q      <= (gap_q == TICK_GAP - 1) ? 0 : gap_q + 1;
      instr_tick <= (gap_q == TICK_GAP - 1);
      return_from_irq_instr_exec  <= (isr_q == 1);
      if (irq_enter)
      begin
        depth_q <= depth_q + 1;
        isr_q   <= ISR_LEN;
      end
      else if (isr_q > 0)
      begin
        isr_q <= isr_q - 1;
        if (isr_q == 1)
          depth_q <= depth_q - 1;
      end
    end
  end
endmodule : vic_core_model

// file: verification/vic_monitor.sv
// Purpose: Port-level checks of the interrupt controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes  : Bound to vic_top below.
`timescale 1ns/1ns
module vic_monitor
  import vic_pkg::*;
(
  input wire logic       pclk,          // Clock.
  input wire logic       presetn,       // Reset.
  input wire logic       psel,          // Select.
  input wire logic       penable,       // Enable.
  input wire logic       pready,        // Ready.
  input wire logic       pslverr,       // Error.
  input wire logic       instr_tick,    // Phase-two pulse.
  input wire logic       sleep_mode,    // Sleep.
  input wire logic       stack_full,    // Stack full.
  input wire logic       return_from_irq_instr_exec,     // Return executed.
  input wire logic       pull_high_en,  // Pull-high request.
  input wire logic       irq_enter,     // Entry pulse.
  input wire logic [7:0] irq_vector,    // Vector.
  input wire logic       pc_pop,        // Pop pulse.
  input wire logic       wake_req,      // Wake request.
  input wire logic       pull_high_out  // Pull-high drive.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  vec_legal_a: assert property (irq_enter |->
    irq_vector inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14})
    else $error("vector outside the table");
  enter_tick_a: assert property (irq_enter |->
    $past(instr_tick, 2) || $past(stack_full, 2))
    else $error("entry not aligned to an instruction cycle");
  enter_stack_a: assert property (irq_enter |-> !$past(stack_full))
    else $error("entry while stack full");
  no_nest_a: assert property (irq_enter |=> !irq_enter [*3])
    else $error("entry repeated too soon");
  pop_return_from_irq_instr_a: assert property (return_from_irq_instr_exec |=> pc_pop)
    else $error("no pop after return");
  pop_cause_a: assert property (pc_pop |-> $past(return_from_irq_instr_exec))
    else $error("pop without return");
  wake_sleep_a: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request outside sleep");
  pull_keep_a: assert property ($past(presetn) |-> pull_high_out == $past(pull_high_en))
    else $error("pull-high not passed on");
  ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");

  cover property (irq_enter && irq_vector == 8'h14);
  cover property (pc_pop);
  cover property (pslverr);
  cover property (wake_req);
endmodule : vic_monitor

bind vic_top vic_monitor u_mon (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .instr_tick, .sleep_mode, .stack_full, .return_from_irq_instr_exec, .pull_high_en, .irq_enter,
  .irq_vector, .pc_pop, .wake_req, .pull_high_out);

// file: verification/vic_top_tb.sv
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Zero-wait APB slave, core model ticking every third clock.
// Notes  : Random flag sets drive the priority rounds.
`timescale 1ns/1ns
module vic_top_tb
  import vic_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, instr_tick, stack_full, return_from_irq_instr_exec;
  logic        instr_long = 1'b0, sleep_mode = 1'b0, ext_pin = 1'b1;
  logic        port_a_dir_bit3 = 1'b0, pull_high_en = 1'b0, hold_full = 1'b0;
  logic [3:0]  evt = 4'h0;
  logic        irq_enter, pc_pop, wake_req, pull_high_out;
  logic [7:0]  irq_vector, m, v;
  logic [7:0]  ofs [3] = '{VIC_OFS_PRIMARY, VIC_OFS_SECONDARY, VIC_OFS_EDGE};
  int          error_cnt = 0, n_tests = 0, cycles = 0, enter_cnt = 0, pop_cnt = 0, n, k;
  integer      seed = 32'hf7b341a6;

  vic_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_tick, .instr_long, .sleep_mode, .stack_full, .return_from_irq_instr_exec,
    .ext_pin, .port_a_dir_bit3, .pull_high_en, .timer0_ovf(evt[0]), .timer1_ovf(evt[1]),
    .conv_done(evt[2]), .timebase_ovf(evt[3]), .irq_enter, .irq_vector, .pc_pop,
    .wake_req, .pull_high_out);
  vic_core_model core (.pclk, .presetn, .irq_enter, .hold_full, .instr_tick,
    .return_from_irq_instr_exec, .stack_full);

  always #20 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cycles++;
    pull_high_en <= 1'($random(seed));
    if (irq_enter === 1'b1)
      enter_cnt++;
    if (pc_pop === 1'b1)
      pop_cnt++;
    if (cycles == 20000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // The leading edge keeps a release and the next request in separate steps.
  task automatic apb(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_enter(output int ticks);
    ticks = 0;
    do
    begin
      @(posedge pclk);
      if (irq_enter !== 1'b1 && instr_tick === 1'b1)
        ticks++;
    end while (irq_enter !== 1'b1);
    v = irq_vector;
  endtask : wait_enter

  function automatic logic [7:0] exp_vec(logic [4:0] fl);
    for (int i = 0; i < 5; i++)
      if (fl[i])
        return 8'h04 + 8'(4 * i);
    return 8'h00;
  endfunction : exp_vec

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b0, ofs[i], 8'h00);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, VIC_OFS_STATUS, 8'h00);
    chk("status idle", 32'h01, rd);
    apb(1'b0, 8'h10, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, err});
    for (int i = 0; i < 6; i++)
    begin
      m = (i == 0) ? 8'hfe : 8'($random(seed)) & 8'hfe;
      apb(1'b1, VIC_OFS_PRIMARY, m);
      apb(1'b0, VIC_OFS_PRIMARY, 8'h00);
      chk("primary", {24'h0, m & 8'h7f}, rd);
      apb(1'b1, VIC_OFS_SECONDARY, m);
      apb(1'b0, VIC_OFS_SECONDARY, 8'h00);
      chk("secondary", {24'h0, m & 8'h33}, rd);
    end
    k = enter_cnt;
    apb(1'b1, VIC_OFS_PRIMARY, 8'h04);
    apb(1'b1, VIC_OFS_SECONDARY, 8'h02);
    evt <= 4'hf;
    @(posedge pclk);
    evt <= 4'h0;
    repeat (10) @(posedge pclk);
    apb(1'b0, VIC_OFS_PRIMARY, 8'h00);
    chk("event flags", 32'h24, rd);
    apb(1'b0, VIC_OFS_SECONDARY, 8'h00);
    chk("event flags two", 32'h22, rd);
    chk("entries, master off", k, enter_cnt);
    port_a_dir_bit3 <= 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, VIC_OFS_EDGE, 8'(s << 6));
      for (int p = 0; p < 2; p++)
      begin
        apb(1'b1, VIC_OFS_PRIMARY, 8'h02);
        ext_pin <= ~ext_pin;
        repeat (4) @(posedge pclk);
        apb(1'b0, VIC_OFS_PRIMARY, 8'h00);
        chk("pin flag", {27'h0, (ext_pin ? s[0] : s[1]), 4'h2}, rd);
      end
    end
    apb(1'b1, VIC_OFS_EDGE, 8'h00);
    for (int r = 0; r < 4; r++)
    begin
      m = (r == 0) ? 8'h1f : {3'h0, 5'($random(seed))} | 8'h10;
      instr_long <= (r == 1);
      sleep_mode <= (r == 2);
      apb(1'b1, VIC_OFS_SECONDARY, {2'b00, m[4:3], 4'h3});
      apb(1'b1, VIC_OFS_PRIMARY, {1'b0, m[2:0], 4'hf});
      chk("wake request", 32'(r == 2), {31'h0, wake_req});
      while (m != 8'h00)
      begin
        wait_enter(n);
        chk("vector", exp_vec(m[4:0]), v);
        chk("latency", (r == 1 || r == 2) ? 3 : 2, n);
        m = m & (m - 8'h01);
        apb(1'b0, VIC_OFS_PRIMARY, 8'h00);
        chk("after entry", {25'h0, m[2:0], 4'he}, rd);
        apb(1'b0, VIC_OFS_SECONDARY, 8'h00);
        chk("after entry two", {26'h0, m[4:3], 4'h3}, rd);
        if (m != 8'h00)
          apb(1'b1, VIC_OFS_PRIMARY, {1'b0, m[2:0], 4'hf});
      end
    end
    instr_long <= 1'b0;
    sleep_mode <= 1'b0;
    hold_full  <= 1'b1;
    k = enter_cnt;
    apb(1'b1, VIC_OFS_PRIMARY, 8'h25);
    repeat (30) @(posedge pclk);
    chk("entries, stack full", k, enter_cnt);
    hold_full <= 1'b0;
    wait_enter(n);
    chk("vector after pop", 32'h08, {24'h0, v});
    repeat (10) @(posedge pclk);
    chk("pops", enter_cnt, pop_cnt);
    give_verdict();
  end
endmodule : vic_top_tb
